// *** logic/xcvr_regs_pkg.sv ***
// register map, field positions and reset values of the transceiver serial register bank
// assumes: one clock domain, all offsets are byte addresses on the two-wire bus
package xcvr_regs_pkg;

  localparam int BYTE_W = 8;
  localparam int NUM_CFG = 38;
  localparam int NUM_SYNC = 9;

  // readable registers
  localparam logic [7:0] OFS_INTERRUPT_HISTORY = 8'h00;
  localparam logic [7:0] OFS_LIVE_STATUS = 8'h01;

  // flag positions shared by history, status and mask
  localparam int FLAG_SIGNAL_ABSENT = 0;
  localparam int FLAG_FREQ_WINDOW = 1;
  localparam int FLAG_THERMAL_ALARM = 2;
  localparam int FLAG_SYNTH_UNLOCK = 3;
  localparam int FLAG_FIFO_FAULT = 7;
  localparam logic [7:0] FLAG_IMPLEMENTED = 8'h8F;

  // synchroniser lane positions
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_CHIP_SEL = 2;
  localparam int SYN_HOST_IF_SEL = 3;
  localparam int SYN_FLAG_BASE = 4;
  localparam logic [8:0] SYNC_RESET = 9'h00F;

  // configuration register offsets, in slot order
  localparam logic [7:0] CFG_OFFSET [NUM_CFG] = '{
    8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5,
    8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8,
    8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6,
    8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5,
    8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5,
    8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4};

  localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
    8'h04, 8'h00, 8'h67, 8'h50, 8'h01,
    8'hF6, 8'hF6, 8'h28, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00, 8'h0C,
    8'h00, 8'h0D, 8'h00, 8'h00, 8'hAA, 8'h20,
    8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h62, 8'h02, 8'hA8, 8'h4B, 8'h03};

  // slots of registers the bank itself interprets
  localparam int SLOT_IRQ_ENABLE_MASK = 0;
  localparam int SLOT_IRQ_PIN_CONFIG = 4;
  localparam int SLOT_FRAME_PATTERN_B3 = 5;
  localparam int SLOT_FRAME_IGNORE_B3 = 9;
  localparam int SLOT_RX_VCO_N_HI = 15;
  localparam int SLOT_RX_VCO_N_LO = 16;
  localparam int SLOT_TX_VCO_N_HI = 28;
  localparam int SLOT_TX_VCO_N_LO = 29;

  // interrupt pin configuration fields
  localparam int PIN_CFG_OPEN_DRAIN = 0;
  localparam int PIN_CFG_ACTIVE_HIGH = 1;

  // divider limits
  localparam logic [8:0] RX_N_MIN = 9'h080;
  localparam logic [8:0] RX_N_MAX = 9'h1FF;
  localparam logic [8:0] TX_N_MIN = 9'h080;
  localparam logic [8:0] TX_N_MAX = 9'h0FF;

  // serial bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h50;  // arbitrary value

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } bus_state_type;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_REG = 2'b01,
    PH_DATA = 2'b10
  } byte_phase_type;

endpackage : xcvr_regs_pkg

// *** logic/xcvr_serial_regs.sv ***
// two-wire serial slave holding the transceiver register bank and the interrupt pin logic
// assumes: bus pins, selects and alarm flags arrive asynchronously; MCLK_IN far above bus rate
//
// Functional notes
// - registers reachable over the serial bus only while interface select is high (open = high).
// - accesses ignored while chip select low; host keeps it high through the transfer.
// - only history (00) and live status (01) are readable; writes to them ignored.
// - configuration registers A0 to F4 are write-only; reads never return them.
// - history bit0 flags signal absence, bit1 flags frequency outside window.
// - history bit2 set when thermal alarm reports junction at or above threshold.
// - history bit3 set when transmit synthesizer reports loss of lock.
// - history bit7 set when a transmit FIFO overflow or underflow occurred.
// - interrupt enable mask at A0 resets to 04.
// - receive VCO N divider spans 128 to 511; high resets 01, low 00.
// - transmit VCO N divider spans 128 to 255; high resets 01, low 00.
// - loop-mode and enable register at A3 resets to 67.
// - interrupt pin configuration at A5 resets to 01.
// - pattern bytes B0 to B3 form 32-bit pattern, B0 most significant.
// - ignore bytes B4 to B7 form 32-bit mask, B4 most significant, reset zero.
// - top fractional register of each divider resets to 80, lower two zero.
// - recovery config C6 resets to 0C, limiter loss config D1 to 0D.
// - serializer F0=62, F1=02; RF output F3=4B, F4=03 at reset.
// - reading history clears only bits whose alarm condition is gone.
// - a history bit reaches the interrupt pin only when its mask bit is 1.
// - reserved bits 4 to 6 carry no meaning; host must not interpret them.
// - interrupt pin holds its active level while any unmasked history bit is set.
`timescale 1ns/1ps
`default_nettype none

module xcvr_serial_regs
  import xcvr_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
)
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic HOST_IF_SEL_IN,
  input wire logic CHIP_SEL_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic SIGNAL_ABSENT_IN,
  input wire logic FREQ_WINDOW_IN,
  input wire logic THERMAL_ALARM_IN,
  input wire logic SYNTH_UNLOCK_IN,
  input wire logic FIFO_FAULT_IN,
  output logic IRQ_OUT,
  output logic IRQ_OE_OUT,
  output logic [NUM_CFG*BYTE_W-1:0] CFG_BYTES_OUT,
  output logic [31:0] FRAME_PATTERN_OUT,
  output logic [31:0] FRAME_IGNORE_OUT,
  output logic [8:0] RX_VCO_N_OUT,
  output logic [8:0] TX_VCO_N_OUT
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_SYNC-1:0] raw_in;
  logic [NUM_SYNC-1:0] sync1;
  logic [NUM_SYNC-1:0] sync2;
  logic [NUM_SYNC-1:0] sync3;
  logic [NUM_SYNC-1:0] filt;
  logic [NUM_SYNC-1:0] next_filt;

  assign raw_in = {FIFO_FAULT_IN, SYNTH_UNLOCK_IN, THERMAL_ALARM_IN, FREQ_WINDOW_IN,
                   SIGNAL_ABSENT_IN, HOST_IF_SEL_IN, CHIP_SEL_IN, SDA_IN, SCL_IN};

  // a lane only moves once the second and third stage agree
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SYNC; gi++)
    begin : g_filt
      assign next_filt[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : filt[gi];
    end
  endgenerate

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
      sync3 <= SYNC_RESET;
      filt <= SYNC_RESET;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic bus_enabled;
  logic [7:0] live_status;

  assign scl_rise = next_filt[SYN_SCL] & ~filt[SYN_SCL];
  assign scl_fall = ~next_filt[SYN_SCL] & filt[SYN_SCL];
  assign sda_rise = next_filt[SYN_SDA] & ~filt[SYN_SDA];
  assign sda_fall = ~next_filt[SYN_SDA] & filt[SYN_SDA];
  assign bus_enabled = filt[SYN_HOST_IF_SEL] & filt[SYN_CHIP_SEL];

  // reserved bits 4..6 read as zero
  always_comb
  begin
    live_status = '0;
    live_status[FLAG_SIGNAL_ABSENT] = filt[SYN_FLAG_BASE];
    live_status[FLAG_FREQ_WINDOW] = filt[SYN_FLAG_BASE+1];
    live_status[FLAG_THERMAL_ALARM] = filt[SYN_FLAG_BASE+2];
    live_status[FLAG_SYNTH_UNLOCK] = filt[SYN_FLAG_BASE+3];
    live_status[FLAG_FIFO_FAULT] = filt[SYN_FLAG_BASE+4];
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic cfg_hit(input logic [7:0] ofs, input int slot);
    cfg_hit = (CFG_OFFSET[slot] == ofs);
  endfunction : cfg_hit

  logic [7:0] cfg [NUM_CFG];
  logic [7:0] hist;

  // write-only registers read as zero, as do unmapped offsets
  function automatic logic [7:0] read_value(input logic [7:0] ofs, input logic [7:0] h,
                                            input logic [7:0] s);
    if (ofs == OFS_INTERRUPT_HISTORY)
      read_value = h;
    else if (ofs == OFS_LIVE_STATUS)
      read_value = s;
    else
      read_value = 8'h00;
  endfunction : read_value

  // ----------------------------------------------------------------
  // serial slave state machine
  // ----------------------------------------------------------------
  bus_state_type state;
  bus_state_type next_state;
  byte_phase_type phase;
  byte_phase_type next_phase;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] reg_ptr;
  logic [7:0] next_reg_ptr;
  logic read_mode;
  logic next_read_mode;
  logic master_ack;
  logic next_master_ack;
  logic sda_low;
  logic next_sda_low;
  logic wr_strobe;
  logic hist_read_done;

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_reg_ptr = reg_ptr;
    next_read_mode = read_mode;
    next_master_ack = master_ack;
    next_sda_low = sda_low;
    wr_strobe = 1'b0;
    hist_read_done = 1'b0;
    if (!bus_enabled)
    begin
      // deselect aborts any transfer and frees the line at once
      next_state = ST_IDLE;
      next_sda_low = 1'b0;
    end
    else if (filt[SYN_SCL] && sda_fall)
    begin
      next_state = ST_RX;
      next_phase = PH_ADDR;
      next_bit_cnt = '0;
      next_sda_low = 1'b0;
    end
    else if (filt[SYN_SCL] && sda_rise)
    begin
      next_state = ST_IDLE;
      next_sda_low = 1'b0;
    end
    else
    begin
      case (state)
        ST_RX:
        begin
          if (scl_rise && bit_cnt < BITS_PER_BYTE)
          begin
            next_shreg = {shreg[6:0], filt[SYN_SDA]};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == BITS_PER_BYTE)
          begin
            next_state = ST_ACK;
            next_sda_low = 1'b1;
            case (phase)
              PH_ADDR:
              begin
                next_read_mode = shreg[0];
                if (shreg[7:1] != DEV_ADDR)
                begin
                  next_state = ST_IDLE;
                  next_sda_low = 1'b0;
                end
              end
              PH_REG:
                next_reg_ptr = shreg;
              default:
              begin
                wr_strobe = 1'b1;
                next_reg_ptr = reg_ptr + 8'h01;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (phase == PH_ADDR && read_mode)
            begin
              next_state = ST_TX;
              next_shreg = read_value(reg_ptr, hist, live_status);
              next_sda_low = ~next_shreg[7];
              next_bit_cnt = 4'h1;
            end
            else
            begin
              next_state = ST_RX;
              next_sda_low = 1'b0;
              next_bit_cnt = '0;
              next_phase = (phase == PH_ADDR) ? PH_REG : PH_DATA;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == BITS_PER_BYTE)
            begin
              next_state = ST_MACK;
              next_sda_low = 1'b0;
              hist_read_done = (reg_ptr == OFS_INTERRUPT_HISTORY);
            end
            else
            begin
              next_sda_low = ~shreg[6];
              next_shreg = {shreg[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
            next_master_ack = ~filt[SYN_SDA];
          else if (scl_fall)
          begin
            if (master_ack)
            begin
              next_state = ST_TX;
              next_reg_ptr = reg_ptr + 8'h01;
              next_shreg = read_value(reg_ptr + 8'h01, hist, live_status);
              next_sda_low = ~next_shreg[7];
              next_bit_cnt = 4'h1;
            end
            else
              next_state = ST_IDLE;
          end
        end
        default:
          next_sda_low = 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state <= ST_IDLE;
      phase <= PH_ADDR;
      bit_cnt <= '0;
      shreg <= '0;
      reg_ptr <= '0;
      read_mode <= 1'b0;
      master_ack <= 1'b0;
      sda_low <= 1'b0;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      reg_ptr <= next_reg_ptr;
      read_mode <= next_read_mode;
      master_ack <= next_master_ack;
      sda_low <= next_sda_low;
    end
  end

  // ----------------------------------------------------------------
  // interrupt history
  // ----------------------------------------------------------------
  logic [7:0] next_hist;

  // a new alarm in the clearing cycle survives: set is ORed after the clear
  always_comb
  begin
    next_hist = hist_read_done ? (hist & live_status) : hist;
    next_hist = (next_hist | live_status) & FLAG_IMPLEMENTED;
  end

  // contents are undefined by the map; zero is picked for determinism
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      hist <= '0;
    else
      hist <= next_hist;
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] next_cfg [NUM_CFG];

  // offsets 00/01 and unmapped offsets match no slot, so writes there vanish
  always_comb
  begin
    for (int i = 0; i < NUM_CFG; i++)
    begin
      next_cfg[i] = cfg[i];
      if (wr_strobe && cfg_hit(reg_ptr, i))
        next_cfg[i] = shreg;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg[i] <= CFG_RESET[i];
    end
    else
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg[i] <= next_cfg[i];
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic irq_active;
  logic next_irq_out;
  logic next_irq_oe;
  logic [8:0] rx_n_raw;
  logic [8:0] tx_n_raw;
  logic [8:0] next_rx_n;
  logic [8:0] next_tx_n;
  logic [NUM_CFG*BYTE_W-1:0] next_cfg_bytes;

  always_comb
  begin
    // level, not pulse: follows the unmasked history directly
    irq_active = |(hist & cfg[SLOT_IRQ_ENABLE_MASK]);
    if (cfg[SLOT_IRQ_PIN_CONFIG][PIN_CFG_OPEN_DRAIN])
    begin
      next_irq_out = 1'b0;
      next_irq_oe = irq_active;
    end
    else
    begin
      next_irq_out = irq_active ~^ cfg[SLOT_IRQ_PIN_CONFIG][PIN_CFG_ACTIVE_HIGH];
      next_irq_oe = 1'b1;
    end
    rx_n_raw = {cfg[SLOT_RX_VCO_N_HI][0], cfg[SLOT_RX_VCO_N_LO]};
    tx_n_raw = {cfg[SLOT_TX_VCO_N_HI][0], cfg[SLOT_TX_VCO_N_LO]};
    // out-of-range divider words are clamped rather than passed on
    next_rx_n = (rx_n_raw < RX_N_MIN) ? RX_N_MIN : (rx_n_raw > RX_N_MAX) ? RX_N_MAX : rx_n_raw;
    next_tx_n = (tx_n_raw < TX_N_MIN) ? TX_N_MIN : (tx_n_raw > TX_N_MAX) ? TX_N_MAX : tx_n_raw;
    for (int i = 0; i < NUM_CFG; i++)
      next_cfg_bytes[i*BYTE_W +: BYTE_W] = next_cfg[i];
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      IRQ_OUT <= 1'b0;
      IRQ_OE_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      RX_VCO_N_OUT <= RX_N_MIN;
      TX_VCO_N_OUT <= TX_N_MIN;
      CFG_BYTES_OUT <= '0;
      FRAME_PATTERN_OUT <= '0;
      FRAME_IGNORE_OUT <= '0;
    end
    else
    begin
      IRQ_OUT <= next_irq_out;
      IRQ_OE_OUT <= next_irq_oe;
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= next_sda_low;
      RX_VCO_N_OUT <= next_rx_n;
      TX_VCO_N_OUT <= next_tx_n;
      CFG_BYTES_OUT <= next_cfg_bytes;
      FRAME_PATTERN_OUT <= {next_cfg[SLOT_FRAME_PATTERN_B3], next_cfg[SLOT_FRAME_PATTERN_B3+1],
                            next_cfg[SLOT_FRAME_PATTERN_B3+2], next_cfg[SLOT_FRAME_PATTERN_B3+3]};
      FRAME_IGNORE_OUT <= {next_cfg[SLOT_FRAME_IGNORE_B3], next_cfg[SLOT_FRAME_IGNORE_B3+1],
                           next_cfg[SLOT_FRAME_IGNORE_B3+2], next_cfg[SLOT_FRAME_IGNORE_B3+3]};
    end
  end

endmodule : xcvr_serial_regs

`default_nettype wire

// *** bench/xcvr_regs_checker.sv ***
// assertion checker on the register bank ports: bus release, interrupt pin, pattern and divider outputs
// assumes: bound to xcvr_serial_regs, single clock domain
`timescale 1ns/1ps
`default_nettype none

module xcvr_regs_checker
  import xcvr_regs_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic HOST_IF_SEL_IN,
  input wire logic CHIP_SEL_IN,
  input wire logic SDA_OE_OUT,
  input wire logic SIGNAL_ABSENT_IN,
  input wire logic FREQ_WINDOW_IN,
  input wire logic THERMAL_ALARM_IN,
  input wire logic SYNTH_UNLOCK_IN,
  input wire logic FIFO_FAULT_IN,
  input wire logic IRQ_OUT,
  input wire logic IRQ_OE_OUT,
  input wire logic [NUM_CFG*BYTE_W-1:0] CFG_BYTES_OUT,
  input wire logic [31:0] FRAME_PATTERN_OUT,
  input wire logic [31:0] FRAME_IGNORE_OUT,
  input wire logic [8:0] RX_VCO_N_OUT,
  input wire logic [8:0] TX_VCO_N_OUT
);
  logic [7:0] mask;
  logic [7:0] pcfg;
  logic [7:0] alarms;
  logic pin_on;
  logic [31:0] pat;
  logic [31:0] ign;
  logic [8:0] rx;
  logic [8:0] tx;
  assign mask = CFG_BYTES_OUT[8*SLOT_IRQ_ENABLE_MASK +: 8] & FLAG_IMPLEMENTED;
  assign pcfg = CFG_BYTES_OUT[8*SLOT_IRQ_PIN_CONFIG +: 8];
  assign alarms = {FIFO_FAULT_IN, 3'b000, SYNTH_UNLOCK_IN, THERMAL_ALARM_IN, FREQ_WINDOW_IN, SIGNAL_ABSENT_IN};
  // open drain is active when enabled, push-pull when level matches polarity
  assign pin_on = pcfg[0] ? IRQ_OE_OUT : (IRQ_OUT == pcfg[1]);
  assign pat = {CFG_BYTES_OUT[47:40], CFG_BYTES_OUT[55:48], CFG_BYTES_OUT[63:56], CFG_BYTES_OUT[71:64]};
  assign ign = {CFG_BYTES_OUT[79:72], CFG_BYTES_OUT[87:80], CFG_BYTES_OUT[95:88], CFG_BYTES_OUT[103:96]};
  assign rx = {CFG_BYTES_OUT[8*SLOT_RX_VCO_N_HI], CFG_BYTES_OUT[8*SLOT_RX_VCO_N_LO +: 8]};
  assign tx = {CFG_BYTES_OUT[8*SLOT_TX_VCO_N_HI], CFG_BYTES_OUT[8*SLOT_TX_VCO_N_LO +: 8]};

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_if_sel_off;
    (!HOST_IF_SEL_IN) [*8] |-> !SDA_OE_OUT;
  endproperty
  a_if_sel_off: assert property (p_if_sel_off) else $error("data driven while deselected");
  property p_cs_off;
    (!CHIP_SEL_IN) [*8] |-> !SDA_OE_OUT;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("data driven without chip select");
  property p_mask_blocks;
    ($stable(pcfg) && mask == 8'h00) [*3] |-> !pin_on;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("pin active with all masked");
  property p_alarm_holds;
    ($stable(pcfg) && $stable(mask) && (alarms & mask) != 8'h00) [*8] |-> pin_on;
  endproperty
  a_alarm_holds: assert property (p_alarm_holds) else $error("pin idle under alarm");
  property p_pattern;
    $stable(pat) [*2] |-> FRAME_PATTERN_OUT == pat;
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern byte order");
  property p_ignore;
    $stable(ign) [*2] |-> FRAME_IGNORE_OUT == ign;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignore byte order");
  property p_rx_n;
    $stable(rx) [*2] |-> RX_VCO_N_OUT == ((rx < RX_N_MIN) ? RX_N_MIN : rx);
  endproperty
  a_rx_n: assert property (p_rx_n) else $error("rx divider range");
  property p_tx_n;
    $stable(tx) [*2] |-> TX_VCO_N_OUT == ((tx < TX_N_MIN) ? TX_N_MIN : ((tx > TX_N_MAX) ? TX_N_MAX : tx));
  endproperty
  a_tx_n: assert property (p_tx_n) else $error("tx divider range");
  c_irq_on: cover property (pin_on && mask != 8'h00);
  c_ack: cover property ($rose(SDA_OE_OUT));
  c_tx_clamp: cover property (tx > TX_N_MAX && TX_VCO_N_OUT == TX_N_MAX);
endmodule : xcvr_regs_checker

bind xcvr_serial_regs xcvr_regs_checker i_xcvr_regs_checker (
  .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .HOST_IF_SEL_IN(HOST_IF_SEL_IN), .CHIP_SEL_IN(CHIP_SEL_IN),
  .SDA_OE_OUT(SDA_OE_OUT), .SIGNAL_ABSENT_IN(SIGNAL_ABSENT_IN), .FREQ_WINDOW_IN(FREQ_WINDOW_IN),
  .THERMAL_ALARM_IN(THERMAL_ALARM_IN), .SYNTH_UNLOCK_IN(SYNTH_UNLOCK_IN), .FIFO_FAULT_IN(FIFO_FAULT_IN),
  .IRQ_OUT(IRQ_OUT), .IRQ_OE_OUT(IRQ_OE_OUT), .CFG_BYTES_OUT(CFG_BYTES_OUT),
  .FRAME_PATTERN_OUT(FRAME_PATTERN_OUT), .FRAME_IGNORE_OUT(FRAME_IGNORE_OUT),
  .RX_VCO_N_OUT(RX_VCO_N_OUT), .TX_VCO_N_OUT(TX_VCO_N_OUT));

`default_nettype wire

// *** bench/host_bus_model.sv ***
// two-wire bus master standing in for the host controller
// assumes: data line pulled up, slave only pulls it low
`timescale 1ns/1ps
`default_nettype none

module host_bus_model
(
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_rel_out
);
  // slave filter and output register lag 4 clocks behind an edge; 8 per half period leaves margin
  localparam int HALF = 8;
  initial
  begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  // data moves only mid-low, far from clock edges, so no false start or stop
  task automatic bit_io(input logic b, output logic got);
    sda_rel_out <= b;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    got = sda_in;
    scl_out <= 1'b0;
    wt(HALF);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], got[i]);
    bit_io(1'b1, ack);
  endtask : byte_io
  task automatic start();
    sda_rel_out <= 1'b1;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    sda_rel_out <= 1'b0;
    wt(HALF);
    scl_out <= 1'b0;
    wt(HALF);
  endtask : start
  task automatic stop();
    sda_rel_out <= 1'b0;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    sda_rel_out <= 1'b1;
    wt(HALF);
  endtask : stop
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, output logic ok);
    logic [7:0] g;
    logic a0;
    logic a1;
    logic a2;
    start();
    byte_io({dev, 1'b0}, g, a0);
    byte_io(ofs, g, a1);
    byte_io(d, g, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : write_reg
  // single byte read, ended by a not-acknowledge
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic [7:0] g;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    byte_io({dev, 1'b0}, g, a0);
    byte_io(ofs, g, a1);
    start();
    byte_io({dev, 1'b1}, g, a2);
    byte_io(8'hFF, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask : read_reg
endmodule : host_bus_model

`default_nettype wire

// *** bench/transceiver_serial_register_map_tb.sv ***
// self-checking bench: register writes and reads, alarms, history and interrupt pin
// assumes: host_bus_model as bus master, checker bound to the bank
`timescale 1ns/1ps
`default_nettype none

module transceiver_serial_register_map_tb;
  import xcvr_regs_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic if_sel = 1'b1;
  logic chip_sel = 1'b1;
  logic [4:0] flags = 5'h00;
  logic [6:0] dev = DEFAULT_DEV_ADDR;
  logic scl;
  logic sda_rel;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic irq_out;
  logic irq_oe;
  logic [NUM_CFG*BYTE_W-1:0] cfg_bytes;
  logic [31:0] frame_pat;
  logic [31:0] frame_ign;
  logic [8:0] rx_n;
  logic [8:0] tx_n;
  logic [7:0] cfg_model [int];
  logic [7:0] hist = 8'h00;
  logic [8:0] nv [5] = '{9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h1FF};
  logic [7:0] probe [6] = '{8'hA0, 8'hF4, 8'hA2, 8'h02, 8'h00, 8'h01};
  int seed;
  int bad_count = 0;
  int num_checks = 0;

  always #5 mclk = ~mclk;
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

  xcvr_serial_regs i_xcvr_serial_regs (
    .MCLK_IN(mclk), .RST_N_IN(rst_n), .HOST_IF_SEL_IN(if_sel), .CHIP_SEL_IN(chip_sel),
    .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe),
    .SIGNAL_ABSENT_IN(flags[0]), .FREQ_WINDOW_IN(flags[1]), .THERMAL_ALARM_IN(flags[2]),
    .SYNTH_UNLOCK_IN(flags[3]), .FIFO_FAULT_IN(flags[4]), .IRQ_OUT(irq_out), .IRQ_OE_OUT(irq_oe),
    .CFG_BYTES_OUT(cfg_bytes), .FRAME_PATTERN_OUT(frame_pat), .FRAME_IGNORE_OUT(frame_ign),
    .RX_VCO_N_OUT(rx_n), .TX_VCO_N_OUT(tx_n));
  host_bus_model i_host_bus_model (.clk_in(mclk), .sda_in(sda_line), .scl_out(scl), .sda_rel_out(sda_rel));

  // ----------------------------------------
  // reference model and checks
  // ----------------------------------------
  function automatic logic [7:0] fmap(input logic [4:0] f);
    return {f[4], 3'b000, f[3:0]};
  endfunction : fmap
  function automatic int clamp(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_outputs();
    repeat (4) @(posedge mclk);
    for (int i = 0; i < NUM_CFG; i++)
      check($sformatf("cfg %h", CFG_OFFSET[i]), cfg_model[CFG_OFFSET[i]], cfg_bytes[8*i +: 8]);
    check("pattern", {cfg_model[8'hB0], cfg_model[8'hB1], cfg_model[8'hB2], cfg_model[8'hB3]}, frame_pat);
    check("ignore", {cfg_model[8'hB4], cfg_model[8'hB5], cfg_model[8'hB6], cfg_model[8'hB7]}, frame_ign);
    check("rx n", clamp({cfg_model[8'hC1][0], cfg_model[8'hC2]}, 128, 511), rx_n);
    check("tx n", clamp({cfg_model[8'hE1][0], cfg_model[8'hE2]}, 128, 255), tx_n);
  endtask : check_outputs
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic take);
    logic ok;
    i_host_bus_model.write_reg(dev, ofs, d, ok);
    check("write ack", take, ok);
    if (take && cfg_model.exists(ofs))
      cfg_model[ofs] = d;
    check_outputs();
  endtask : wr
  task automatic rd(input logic [7:0] ofs);
    logic [7:0] d;
    logic [7:0] exp;
    logic ok;
    exp = (ofs == 8'h00) ? hist : ((ofs == 8'h01) ? fmap(flags) : 8'h00);
    i_host_bus_model.read_reg(dev, ofs, d, ok);
    check("read ack", 1'b1, ok);
    // reserved bits 4 to 6 carry no meaning
    check($sformatf("read %h", ofs), exp & 8'h8F, d & 8'h8F);
    if (ofs == 8'h00)
      hist = fmap(flags);
  endtask : rd
  task automatic set_flags(input logic [4:0] f);
    @(posedge mclk);
    flags <= f;
    hist = hist | fmap(f);
    repeat (10) @(posedge mclk);
  endtask : set_flags
  task automatic check_irq();
    logic act;
    logic [7:0] pc;
    repeat (4) @(posedge mclk);
    pc = cfg_model[8'hA5];
    act = |(hist & cfg_model[8'hA0]);
    check("irq enable", pc[0] ? act : 1'b1, irq_oe);
    check("irq level", pc[0] ? 1'b0 : (pc[1] ? act : !act), irq_out);
  endtask : check_irq
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    #950_000;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    seed = $urandom(50);
    for (int i = 0; i < NUM_CFG; i++)
      cfg_model[CFG_OFFSET[i]] = CFG_RESET[i];
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    check_outputs();
    for (int i = 0; i < NUM_CFG; i++)
      wr(CFG_OFFSET[i], 8'($urandom), 1'b1);
    foreach (probe[i])
      wr(probe[i], 8'h5A, 1'b1);
    foreach (probe[i])
      rd(probe[i]);
    foreach (nv[i])
    begin
      wr(8'hC1, {7'h00, nv[i][8]}, 1'b1);
      wr(8'hC2, nv[i][7:0], 1'b1);
      wr(8'hE1, {7'h00, nv[i][8]}, 1'b1);
      wr(8'hE2, nv[i][7:0], 1'b1);
    end
    if_sel <= 1'b0;
    wr(8'hB0, 8'h11, 1'b0);
    if_sel <= 1'b1;
    chip_sel <= 1'b0;
    wr(8'hB1, 8'h22, 1'b0);
    chip_sel <= 1'b1;
    dev = DEFAULT_DEV_ADDR ^ 7'h01;
    wr(8'hB2, 8'h33, 1'b0);
    dev = DEFAULT_DEV_ADDR;
    wr(8'hA5, 8'h01, 1'b1);
    wr(8'hA0, 8'h04, 1'b1);
    set_flags(5'b00001);
    check_irq();
    rd(8'h00);
    set_flags(5'b00000);
    rd(8'h00);
    rd(8'h00);
    set_flags(5'b00100);
    check_irq();
    repeat (50) @(posedge mclk);
    rd(8'h00);
    check_irq();
    wr(8'hA0, 8'h00, 1'b1);
    check_irq();
    rd(8'h00);
    wr(8'hA0, 8'h8F, 1'b1);
    wr(8'hA5, 8'h02, 1'b1);
    check_irq();
    wr(8'hA5, 8'h00, 1'b1);
    check_irq();
    repeat (4)
    begin
      set_flags(5'($urandom));
      rd(8'h01);
      rd(8'h00);
      check_irq();
    end
    give_verdict();
  end
endmodule : transceiver_serial_register_map_tb

`default_nettype wire
